// File: hw/rsse_defs.svh
// Constants for the rotate / fill / sleep execution block
`ifndef RSSE_DEFS_SVH
`define RSSE_DEFS_SVH
`define RSSE_OPC_ROT 6'h10
`define RSSE_OPC_FILL 7'h34
`define RSSE_OPC_SLEEP 16'h0003
`define RSSE_ILO_MAX 8'h5f
`define RSSE_ONES 8'hff
`define RSSE_ACC_HI_BANK 4'hf
`define RSSE_ACC_SPLIT 8'h60
`define RSSE_Q_LAST 2'h3
`define RSSE_A_CTRL 32'h00
`define RSSE_A_INSN 32'h04
`define RSSE_A_STAT 32'h08
`define RSSE_A_WREG 32'h0c
`define RSSE_A_WAKE 32'h10
`define RSSE_A_DATA 32'h14
`define RSSE_BRESP_OK 2'h0
`define RSSE_BRESP_ERR 2'h2
`endif

// File: hw/rsse_pkg.sv
// Types for the rotate / fill / sleep execution block
package rsse_pkg;
  typedef enum logic [1:0] {
    RSSE_Q1 = 2'h0,
    RSSE_Q2 = 2'h1,
    RSSE_Q3 = 2'h3,
    RSSE_Q4 = 2'h2
  } rsse_q_t;
  typedef struct packed {
    logic we;
    logic [11:0] addr;
    logic [7:0] wdata;
  } rsse_mem_req_t;
endpackage

// File: hw/rsse_exec.sv
// Execution core: decodes one instruction word over four quarter cycles
`timescale 1ns/1ps
`include "rsse_defs.svh"
module rsse_exec
  import rsse_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [15:0] insn,
  input wire logic [3:0] bank_ptr,
  input wire logic ext_en,
  input wire logic [11:0] fsr2,
  input wire logic [7:0] rdata,
  output logic busy,
  output logic [11:0] addr,
  output logic mem_we,
  output logic [7:0] mem_wdata,
  output logic w_we,
  output logic [7:0] w_wdata,
  output logic flag_we,
  output logic neg,
  output logic zero,
  output logic sleep_ev
);
  rsse_q_t q_r, q_nxt;
  logic busy_r, busy_nxt;
  logic [15:0] ir_r, ir_nxt;
  logic [7:0] data_r, data_nxt;
  logic is_rot, is_fill, is_sleep;
  logic [7:0] rot;
  always_comb begin
    is_rot = ir_r[15:10] == `RSSE_OPC_ROT;
    is_fill = ir_r[15:9] == `RSSE_OPC_FILL;
    is_sleep = ir_r == `RSSE_OPC_SLEEP;
    rot = {data_r[0], data_r[7:1]};
    // Bank select: access bank, indexed literal offset, or bank pointer
    if (ir_r[8]) begin
      addr = {bank_ptr, ir_r[7:0]};
    end else if (ext_en && ir_r[7:0] <= `RSSE_ILO_MAX) begin
      addr = fsr2 + {4'h0, ir_r[7:0]};
    end else if (ir_r[7:0] >= `RSSE_ACC_SPLIT) begin
      addr = {`RSSE_ACC_HI_BANK, ir_r[7:0]};
    end else begin
      addr = {4'h0, ir_r[7:0]};
    end
    q_nxt = q_r;
    busy_nxt = busy_r;
    ir_nxt = ir_r;
    data_nxt = data_r;
    mem_we = 1'b0;
    mem_wdata = rot;
    w_we = 1'b0;
    w_wdata = rot;
    flag_we = 1'b0;
    sleep_ev = 1'b0;
    neg = rot[7];
    zero = rot == 8'h00;
    unique case (q_r)
      RSSE_Q1: begin
        if (start && !busy_r) begin
          ir_nxt = insn;
          busy_nxt = 1'b1;
          q_nxt = RSSE_Q2;
        end
      end
      RSSE_Q2: begin
        data_nxt = rdata;
        q_nxt = RSSE_Q3;
      end
      RSSE_Q3: q_nxt = RSSE_Q4;
      RSSE_Q4: begin
        // Single-cycle instruction finishes its write here
        if (is_rot) begin
          flag_we = 1'b1;
          mem_we = ir_r[9];
          w_we = !ir_r[9];
        end else if (is_fill) begin
          mem_we = 1'b1;
          mem_wdata = `RSSE_ONES;
        end else if (is_sleep) begin
          sleep_ev = 1'b1;
        end
        busy_nxt = 1'b0;
        q_nxt = RSSE_Q1;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      q_r <= RSSE_Q1;
      busy_r <= 1'b0;
      ir_r <= 16'h0000;
      data_r <= 8'h00;
    end else begin
      q_r <= q_nxt;
      busy_r <= busy_nxt;
      ir_r <= ir_nxt;
      data_r <= data_nxt;
    end
  end
  assign busy = busy_r;
endmodule

// File: hw/rsse_top.sv
// Register-bus wrapper with data memory, working register and status flags
// Functional notes
// - Rotate right without carry: bit0 moves to bit7, others shift down.
// - Destination bit zero writes W; one writes back to file register.
// - Bank bit zero forces access bank; one uses bank pointer register.
// - Access bank with extended set and address up to 95 uses indexed offset.
// - Fill opcode writes all ones and leaves every flag untouched.
// - Fill opcode is 0110 100a; bank bit chooses access bank or pointer.
// - Sleep clears power-down, sets expiry flag, clears watchdog, then halts.
// - Watchdog wake from sleep clears the expiry flag.
`timescale 1ns/1ps
`include "rsse_defs.svh"
module rsse_top
  import rsse_pkg::*;
#(
  parameter int MEM_DEPTH = 4096
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic SRST,
  // Wake source
  input wire logic WDT_WAKE,
  // AXI4-Lite write
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Core state
  output logic SLEEPING,
  output logic [7:0] WREG
);
  // Bank and offset fields reach exactly 4096 bytes, no more and no fewer
  if (MEM_DEPTH != 4096) begin : g_depth_check
    $error("MEM_DEPTH must be 4096");
  end
  logic [7:0] mem [MEM_DEPTH];
  logic aw_ok_r, aw_ok_nxt, w_ok_r, w_ok_nxt, bv_r, bv_nxt, ar_ok_r, ar_ok_nxt, rv_r, rv_nxt;
  logic [31:0] awa_r, awa_nxt, wd_r, wd_nxt, rd_r, rd_nxt;
  logic [3:0] ws_r, ws_nxt;
  logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
  logic [3:0] bank_r, bank_nxt;
  logic ext_r, ext_nxt, go_r, go_nxt;
  logic [11:0] fsr2_r, fsr2_nxt;
  logic [15:0] insn_r, insn_nxt;
  logic [7:0] w_r, w_nxt;
  logic n_r, n_nxt, z_r, z_nxt, to_n_r, to_n_nxt, pd_n_r, pd_n_nxt, slp_r, slp_nxt;
  logic [7:0] wdtc_r, wdtc_nxt;
  logic busy, mem_we, w_we, flag_we, neg, zero, sleep_ev, do_w, ld_we;
  logic [11:0] ex_addr;
  logic [7:0] mem_wdata, w_wdata;
  rsse_mem_req_t req;
  rsse_exec i_rsse_exec (
    .clk(MCLK), .rst(SRST), .start(go_r && !slp_r), .insn(insn_r),
    .bank_ptr(bank_r), .ext_en(ext_r), .fsr2(fsr2_r), .rdata(mem[ex_addr]),
    .busy(busy), .addr(ex_addr), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .w_we(w_we), .w_wdata(w_wdata), .flag_we(flag_we),
    .neg(neg), .zero(zero), .sleep_ev(sleep_ev)
  );
  always_comb begin
    req.we = mem_we;
    req.addr = ex_addr;
    req.wdata = mem_wdata;
    // Loads are only taken while the core is idle, so the two never collide
    if (ld_we) begin
      req.we = 1'b1;
      req.addr = wd_r[27:16];
      req.wdata = wd_r[7:0];
    end
  end
  always_ff @(posedge MCLK) begin
    if (req.we) begin
      mem[req.addr] <= req.wdata;
    end
  end
  always_comb begin
    aw_ok_nxt = aw_ok_r;
    w_ok_nxt = w_ok_r;
    awa_nxt = awa_r;
    wd_nxt = wd_r;
    ws_nxt = ws_r;
    bv_nxt = bv_r;
    br_nxt = br_r;
    ar_ok_nxt = 1'b0;
    rv_nxt = rv_r;
    rd_nxt = rd_r;
    rr_nxt = rr_r;
    bank_nxt = bank_r;
    ext_nxt = ext_r;
    fsr2_nxt = fsr2_r;
    insn_nxt = insn_r;
    ld_we = 1'b0;
    go_nxt = go_r && busy ? 1'b0 : go_r;
    w_nxt = w_we ? w_wdata : w_r;
    n_nxt = flag_we ? neg : n_r;
    z_nxt = flag_we ? zero : z_r;
    to_n_nxt = to_n_r;
    pd_n_nxt = pd_n_r;
    slp_nxt = slp_r;
    wdtc_nxt = slp_r ? wdtc_r + 8'h01 : wdtc_r;
    if (S_AXI_AWVALID && !aw_ok_r) begin
      aw_ok_nxt = 1'b1;
      awa_nxt = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !w_ok_r) begin
      w_ok_nxt = 1'b1;
      wd_nxt = S_AXI_WDATA;
      ws_nxt = S_AXI_WSTRB;
    end
    do_w = aw_ok_r && w_ok_r && !bv_r;
    if (do_w) begin
      aw_ok_nxt = 1'b0;
      w_ok_nxt = 1'b0;
      bv_nxt = 1'b1;
      br_nxt = `RSSE_BRESP_OK;
      unique case (awa_r)
        `RSSE_A_CTRL: begin
          if (ws_r[0]) begin
            bank_nxt = wd_r[3:0];
            ext_nxt = wd_r[4];
          end
          if (ws_r[2]) fsr2_nxt[7:0] = wd_r[23:16];
          if (ws_r[3]) fsr2_nxt[11:8] = wd_r[27:24];
        end
        `RSSE_A_INSN: begin
          insn_nxt = wd_r[15:0];
          go_nxt = 1'b1;
        end
        `RSSE_A_DATA: begin
          // Direct data-memory load; refused while an instruction owns the port
          if (busy) begin
            br_nxt = `RSSE_BRESP_ERR;
          end else begin
            ld_we = 1'b1;
          end
        end
        default: br_nxt = `RSSE_BRESP_ERR;
      endcase
    end
    if (bv_r && S_AXI_BREADY) bv_nxt = 1'b0;
    if (S_AXI_ARVALID && !rv_r && !ar_ok_r) begin
      ar_ok_nxt = 1'b1;
      rv_nxt = 1'b1;
      rr_nxt = `RSSE_BRESP_OK;
      unique case (S_AXI_ARADDR)
        `RSSE_A_CTRL: rd_nxt = {4'h0, fsr2_r, 11'h000, ext_r, bank_r};
        `RSSE_A_INSN: rd_nxt = {16'h0000, insn_r};
        `RSSE_A_STAT: rd_nxt = {24'h0, 2'h0, slp_r, busy, to_n_r, pd_n_r, z_r, n_r};
        `RSSE_A_WREG: rd_nxt = {24'h0, w_r};
        `RSSE_A_WAKE: rd_nxt = {24'h0, wdtc_r};
        default: begin
          rd_nxt = 32'h0;
          rr_nxt = `RSSE_BRESP_ERR;
        end
      endcase
    end else if (rv_r && S_AXI_RREADY) begin
      rv_nxt = 1'b0;
    end
    if (sleep_ev) begin
      pd_n_nxt = 1'b0;
      to_n_nxt = 1'b1;
      wdtc_nxt = 8'h00;
      slp_nxt = 1'b1;
    end else if (slp_r && WDT_WAKE) begin
      to_n_nxt = 1'b0;
      slp_nxt = 1'b0;
    end
  end
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      bv_r <= 1'b0;
      ar_ok_r <= 1'b0;
      rv_r <= 1'b0;
      awa_r <= 32'h0;
      wd_r <= 32'h0;
      ws_r <= 4'h0;
      rd_r <= 32'h0;
      br_r <= 2'h0;
      rr_r <= 2'h0;
      bank_r <= 4'h0;
      ext_r <= 1'b0;
      go_r <= 1'b0;
      fsr2_r <= 12'h000;
      insn_r <= 16'h0000;
      w_r <= 8'h00;
      n_r <= 1'b0;
      z_r <= 1'b0;
      to_n_r <= 1'b1;
      pd_n_r <= 1'b1;
      slp_r <= 1'b0;
      wdtc_r <= 8'h00;
    end else begin
      aw_ok_r <= aw_ok_nxt;
      w_ok_r <= w_ok_nxt;
      bv_r <= bv_nxt;
      ar_ok_r <= ar_ok_nxt;
      rv_r <= rv_nxt;
      awa_r <= awa_nxt;
      wd_r <= wd_nxt;
      ws_r <= ws_nxt;
      rd_r <= rd_nxt;
      br_r <= br_nxt;
      rr_r <= rr_nxt;
      bank_r <= bank_nxt;
      ext_r <= ext_nxt;
      go_r <= go_nxt;
      fsr2_r <= fsr2_nxt;
      insn_r <= insn_nxt;
      w_r <= w_nxt;
      n_r <= n_nxt;
      z_r <= z_nxt;
      to_n_r <= to_n_nxt;
      pd_n_r <= pd_n_nxt;
      slp_r <= slp_nxt;
      wdtc_r <= wdtc_nxt;
    end
  end
  assign S_AXI_AWREADY = aw_ok_r;
  assign S_AXI_WREADY = w_ok_r;
  assign S_AXI_BVALID = bv_r;
  assign S_AXI_BRESP = br_r;
  assign S_AXI_ARREADY = ar_ok_r;
  assign S_AXI_RVALID = rv_r;
  assign S_AXI_RDATA = rd_r;
  assign S_AXI_RRESP = rr_r;
  assign SLEEPING = slp_r;
  assign WREG = w_r;
  property p_sleep_flags;
    @(posedge MCLK) disable iff (SRST) sleep_ev |=> (!pd_n_r && to_n_r && slp_r);
  endproperty
  a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags wrong");
  property p_wake_clear;
    @(posedge MCLK) disable iff (SRST) (slp_r && WDT_WAKE && !sleep_ev) |=> !to_n_r && !slp_r;
  endproperty
  a_wake_clear: assert property (p_wake_clear) else $error("wake did not clear flag");
  property p_w_dest;
    @(posedge MCLK) disable iff (SRST) w_we |=> w_r == $past(w_wdata);
  endproperty
  a_w_dest: assert property (p_w_dest) else $error("W not written");
  property p_flags_hold;
    @(posedge MCLK) disable iff (SRST) !flag_we |=> $stable(n_r) && $stable(z_r);
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("flags changed");
  property p_one_cycle;
    @(posedge MCLK) disable iff (SRST) $rose(busy) |-> busy [*3] ##1 !busy;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("not four quarters");
  property p_rot_val;
    @(posedge MCLK) disable iff (SRST)
      (mem_we && mem_wdata != `RSSE_ONES) |-> mem_wdata == {mem[ex_addr][0], mem[ex_addr][7:1]};
  endproperty
  a_rot_val: assert property (p_rot_val) else $error("rotate wrong");
  property p_excl;
    @(posedge MCLK) disable iff (SRST) !(mem_we && w_we);
  endproperty
  a_excl: assert property (p_excl) else $error("two destinations");
  property p_bank;
    @(posedge MCLK) disable iff (SRST) (mem_we && insn_r[8]) |-> ex_addr[11:8] == bank_r;
  endproperty
  a_bank: assert property (p_bank) else $error("bank pointer unused");
endmodule

// File: bench/rsse_host.sv
// AXI4-Lite master standing in for the core's fetch side
`timescale 1ns/1ps
module rsse_host (
  // Clock
  input wire logic clk,
  // Write channels
  output logic [31:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // Read channels
  output logic [31:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  int hangs = 0;
  logic [1:0] rr_seen;
  initial begin
    awaddr = 32'h0;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hf;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 32'h0;
    arvalid = 1'b0;
    rready = 1'b0;
    rr_seen = 2'h0;
  end
  // Address and data valids drop at the edge their ready is seen; bready and rready drop at the edge bvalid or rvalid is seen
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    bit b;
    int n;
    b = 0;
    n = 0;
    r = 2'h3;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b && n < 100) begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        b = 1;
        r = bresp;
        bready <= 1'b0;
      end
    end
    if (!b) hangs++;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    bit got;
    int n;
    got = 0;
    n = 0;
    d = 32'h0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got && n < 100) begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        got = 1;
        d = rdata;
        rr_seen = rresp;
        rready <= 1'b0;
      end
    end
    if (!got) hangs++;
  endtask
endmodule

// File: bench/rotate_set_sleep_exec_tb.sv
// Self-checking bench for the rotate / fill / sleep block
`timescale 1ns/1ps
module rotate_set_sleep_exec_tb;
  logic mclk, srst, wdt_wake, sleeping, ext, a1;
  logic [7:0] wreg, f, v;
  logic [31:0] awaddr, wdata, araddr, rdata, s, c;
  logic [3:0] wstrb, bp;
  logic [1:0] bresp, rresp, r;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [11:0] base, p;
  int bad_count = 0;
  int tests_run = 0;
  int n;
  rsse_top i_rsse_top (.MCLK(mclk), .SRST(srst), .WDT_WAKE(wdt_wake),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .SLEEPING(sleeping), .WREG(wreg));
  rsse_host i_rsse_host (.clk(mclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [7:0] rotr(logic [7:0] v);
    return {v[0], v[7:1]};
  endfunction
  // Zero and negative flags of a result, in status bit order
  function automatic logic [1:0] nz(logic [7:0] v);
    return {v == 8'h00, v[7]};
  endfunction
  // Physical byte the fill lands on, from bank bit, extended mode and offset
  function automatic logic [11:0] phys(logic [3:0] b, logic e, logic [11:0] ib, logic a,
      logic [7:0] o);
    if (a) return {b, o};
    if (e && o <= 8'h5f) return ib + {4'h0, o};
    return (o >= 8'h60) ? {4'hf, o} : {4'h0, o};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // Seeds one data byte so that rotates see something other than all ones
  task automatic load(input logic [11:0] a, input logic [7:0] d);
    i_rsse_host.wr(32'h14, {4'h0, a, 8'h0, d}, r);
    check(r, 2'h0, "load response");
  endtask
  // Busy polling is bounded; a core that never finishes ends the run
  task automatic exec(input logic [15:0] op);
    logic [1:0] wr_r;
    logic [31:0] st;
    int k;
    i_rsse_host.wr(32'h04, {16'h0, op}, wr_r);
    st = 32'h10;
    k = 0;
    while (st[4] !== 1'b0 && k < 50) begin
      i_rsse_host.rd(32'h08, st);
      k++;
    end
    if (st[4] !== 1'b0) begin
      $display("unexpected at %0t: core stayed busy", $time);
      bad_count++;
      give_verdict();
    end
  endtask
  task automatic do_reset();
    srst <= 1'b1;
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
  endtask
  task automatic give_verdict();
    bad_count += i_rsse_host.hangs;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    for (int t = 0; t < 60000 && i_rsse_host.hangs == 0; t++) begin
      @(posedge mclk);
    end
    $display("unexpected at %0t: run timed out or bus hung", $time);
    bad_count++;
    give_verdict();
  end
  initial begin
    srst = 1'b1;
    wdt_wake = 1'b0;
    void'($urandom(52));
    // First three passes pin the offset boundary and the plain access bank
    for (int i = 0; i < 8; i++) begin
      do_reset();
      ext = 1'($urandom);
      a1 = 1'($urandom);
      bp = 4'($urandom);
      base = 12'($urandom);
      f = 8'($urandom);
      v = 8'($urandom);
      if (i < 3) begin
        a1 = 1'b0;
        ext = (i != 2);
        f = (i == 0) ? 8'h5f : 8'h60;
        v = (i == 0) ? 8'h00 : 8'h01;
      end
      p = phys(bp, ext, base, a1, f);
      i_rsse_host.wr(32'h00, {4'h0, base, 11'h0, ext, bp}, r);
      load(p, v);
      exec({6'h10, 1'b0, a1, f});
      check(wreg, rotr(v), "W after rotate to W");
      i_rsse_host.rd(32'h08, s);
      check(s[3:0], {2'b11, nz(rotr(v))}, "flags after rotate");
      exec({6'h10, 1'b1, a1, f});
      check(wreg, rotr(v), "W kept by rotate to file");
      exec({6'h10, 1'b0, a1, f});
      check(wreg, rotr(rotr(v)), "W after rotating written-back byte");
      exec({7'h34, a1, f});
      i_rsse_host.rd(32'h08, s);
      check(s[3:0], {2'b11, nz(rotr(rotr(v)))}, "flags after fill");
      exec({6'h10, 1'b0, a1, f});
      check(wreg, 8'hff, "W after rotating filled byte");
    end
    i_rsse_host.wr(32'h20, 32'h0, r);
    check(r, 2'h2, "unmapped write response");
    i_rsse_host.rd(32'h20, s);
    check(i_rsse_host.rr_seen, 2'h2, "unmapped read response");
    exec(16'h0003);
    i_rsse_host.rd(32'h08, s);
    check(s[5:2], 4'b1010, "status after sleep");
    check(sleeping, 1'b1, "sleeping pin");
    repeat (100) @(posedge mclk);
    wdt_wake <= 1'b1;
    n = 0;
    while (sleeping !== 1'b0 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    wdt_wake <= 1'b0;
    check(n < 50, 1'b1, "wake from sleep");
    i_rsse_host.rd(32'h08, s);
    check(s[5:2], 4'b0000, "status after wake");
    i_rsse_host.rd(32'h10, c);
    check(c >= 32'h64, 1'b1, "watchdog count while asleep");
    i_rsse_host.rd(32'h10, s);
    check(s, c, "watchdog count held while awake");
    exec(16'h0003);
    i_rsse_host.rd(32'h10, s);
    check(s < 32'h20, 1'b1, "watchdog cleared by sleep");
    give_verdict();
  end
endmodule
